// File: hw/spm_pkg.sv
`default_nettype none
package spm_pkg;
  // Management register addresses
  localparam logic [4:0] ADDR_CTRL    = 5'h00;
  localparam logic [4:0] ADDR_STAT    = 5'h01;
  localparam logic [4:0] ADDR_ID_HI   = 5'h02;
  localparam logic [4:0] ADDR_ID_LO   = 5'h03;
  localparam logic [4:0] ADDR_ADV     = 5'h04;
  localparam logic [4:0] ADDR_LPA     = 5'h05;
  localparam logic [4:0] ADDR_ANX     = 5'h06;
  localparam logic [4:0] ADDR_NP_TX   = 5'h07;
  localparam logic [4:0] ADDR_NP_RX   = 5'h08;
  localparam logic [4:0] ADDR_EXT     = 5'h0f;
  localparam logic [4:0] ADDR_INT_CTL = 5'h10;
  localparam logic [4:0] ADDR_LB_CTL  = 5'h11;

  // Control register fields
  localparam int CTL_RESET   = 15;
  localparam int CTL_LOOP    = 14;
  localparam int CTL_SPD_LSB = 13;
  localparam int CTL_AN_EN   = 12;
  localparam int CTL_PDOWN   = 11;
  localparam int CTL_ISO     = 10;
  localparam int CTL_AN_RST  = 9;
  localparam int CTL_DUPLEX  = 8;
  localparam int CTL_COLTEST = 7;
  localparam int CTL_SPD_MSB = 6;
  localparam int CTL_UNIDIR  = 5;
  localparam logic [15:0] CTRL_FIXED = 16'h0140;

  // Status register fields
  localparam int STS_AN_DONE = 5;
  localparam int STS_RFAULT  = 4;
  localparam int STS_LINK    = 2;
  localparam logic [15:0] STAT_FIXED = 16'h01c8;

  // Constant and reset values of the other registers
  localparam logic [15:0] ADV_VAL     = 16'h0001;
  localparam logic [15:0] EXT_VAL     = 16'h8000;
  localparam logic [15:0] LPA_RST     = 16'h8001;
  localparam logic [15:0] LPA_MASK    = 16'hdc00;
  localparam logic [15:0] LPA_FIXED   = 16'h0001;
  localparam int          LPA_DUPLEX  = 12;
  localparam int          LPA_SPD_LO  = 10;
  localparam logic [1:0]  SPD_1000    = 2'h1;
  localparam logic [1:0]  SPD_100     = 2'h2;
  localparam logic [1:0]  SPD_10      = 2'h3;
  localparam int          ANX_PG_RX   = 1;
  localparam logic [15:0] ANX_FIXED   = 16'h0004;
  localparam logic [15:0] NP_TX_RST   = 16'h2001;
  localparam logic [15:0] NP_TX_WMASK = 16'hb7ff;
  localparam int          INT_EN      = 0;
  localparam int          INT_STAT    = 1;
  localparam logic        INT_EN_RST  = 1'b1;
  localparam int          LB_POS      = 0;

  typedef struct packed {
    logic        wr;
    logic [4:0]  management_register_address;
    logic [15:0] wdata;
  } spm_mgmt_req_s;

  typedef struct packed {
    logic an_complete;
    logic link_up;
    logic remote_fault;
    logic page_rx;
  } spm_lnk_stat_s;

  typedef struct packed {
    logic lb_en;
    logic lb_pos;
    logic pdown;
    logic iso;
    logic an_en;
    logic unidir;
  } spm_lvl_s;
  localparam spm_lvl_s LVL_RST = 6'h02;

  typedef struct packed {
    logic pcs_reset;
    logic an_restart;
    logic pcs_loopback;
    logic xcvr_loopback;
    logic tx_idle_force;
    logic power_down;
    logic isolate;
    logic an_enable;
    logic unidir;
  } spm_lnk_ctrl_s;
endpackage
`default_nettype wire

// File: hw/spm_sgmii_pcs_mgmt.sv
// Function
// - Serial 1.25 Gb/s link, timing from recovered clock
// - Completion seen by status poll or interrupt
// - PCS loopback: data looped, Idles sent out
// - Transceiver loopback: data looped and still transmitted
// - Control bit 14 enables; register 17 picks position
// - Registers reached by management port, SGMII only
// - Decode 0-8, 15 standard; 16, 17 vendor
// - Control bit 15 resets PCS, self-clears
// - Speed bits constant: 13 reads 0, 6 reads 1
// - Control bit 12 auto-negotiation enable, reset 1
// - Power down sticks until PCS reset
// - Control bit 10 isolate, read/write, reset 0
// - Control bit 9 restarts negotiation, self-clears
// - Bit 8 reads 1, bit 7 and 4:0 zero
// - Control bit 5 unidirectional enable, reset 0
// - Status 15:9 zero; 8,7,6,3 read one
// - Status bit 5 shows negotiation complete
// - Remote fault sticky, cleared by status read
// - Partner ability: speed in 11:10, duplex bit 12
// - Interrupt status set on completion, cleared by write 0
// - Link status latches low, status read reloads current link state
`default_nettype none
module spm_sgmii_pcs_mgmt #(
  parameter logic [15:0] ID_HIGH = 16'h1234, // Arbitrary identity value
  parameter logic [15:0] ID_LOW  = 16'h5678  // Arbitrary identity value
) (
  input  wire logic                   clk_sys,
  input  wire logic                   rst_n,
  input  wire logic                   clk_link,
  input  wire logic                   sgmii_mode,
  input  wire logic                   mgmt_valid,
  input  wire spm_pkg::spm_mgmt_req_s mgmt_cmd,
  output logic                        mgmt_ack,
  output logic [15:0]                 mgmt_rdata,
  output logic [1:0]                  partner_speed,
  output logic                        partner_full_duplex,
  input  wire spm_pkg::spm_lnk_stat_s lnk_stat,
  input  wire logic [15:0]            lnk_partner,
  output spm_pkg::spm_lnk_ctrl_s      lnk_ctrl
);
  import spm_pkg::*;

  function automatic logic spm_mapped(input logic [4:0] a);
    spm_mapped = (a <= ADDR_NP_RX) || (a == ADDR_EXT) || (a == ADDR_INT_CTL) ||
                 (a == ADDR_LB_CTL);
  endfunction

  // Link-to-system crossings
  logic [2:0]  an_sync_q;
  logic [1:0]  lk_sync_q;
  logic [2:0]  rf_sync_q;
  logic [2:0]  pg_sync_q;
  logic [1:0]  pa_req_sync_q;
  logic        an_lvl_q;
  logic        lk_lvl_q;
  logic        rf_tgl_q;
  logic        pg_tgl_q;
  logic        pa_req_q;
  logic [15:0] pa_hold_q;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      an_sync_q     <= 3'h0;
      lk_sync_q     <= 2'h0;
      rf_sync_q     <= 3'h0;
      pg_sync_q     <= 3'h0;
      pa_req_sync_q <= 2'h0;
    end else begin
      an_sync_q     <= {an_sync_q[1:0], an_lvl_q};
      lk_sync_q     <= {lk_sync_q[0], lk_lvl_q};
      rf_sync_q     <= {rf_sync_q[1:0], rf_tgl_q};
      pg_sync_q     <= {pg_sync_q[1:0], pg_tgl_q};
      pa_req_sync_q <= {pa_req_sync_q[0], pa_req_q};
    end
  end

  logic an_done_s;
  logic an_evt;
  logic link_up_s;
  logic rf_evt;
  logic pg_evt;
  assign an_done_s = an_sync_q[1];
  assign an_evt    = an_sync_q[1] & ~an_sync_q[2];
  assign link_up_s = lk_sync_q[1];
  assign rf_evt    = rf_sync_q[1] ^ rf_sync_q[2];
  assign pg_evt    = pg_sync_q[1] ^ pg_sync_q[2];

  // System-side register state
  spm_lvl_s    lvl_q, lvl_d;
  logic        rst_tgl_q, rst_tgl_d;
  logic        rsn_tgl_q, rsn_tgl_d;
  logic        int_en_q, int_en_d;
  logic        int_stat_q, int_stat_d;
  logic        rf_q, rf_d;
  logic        link_lat_q, link_lat_d;
  logic        pgrx_q, pgrx_d;
  logic [15:0] np_tx_q, np_tx_d;
  logic [15:0] partner_q, partner_d;
  logic        pa_ack_q, pa_ack_d;
  logic        ack_q, ack_d;
  logic [15:0] rdata_q, rdata_d;
  logic [1:0]  pspd_q, pspd_d;
  logic        pfd_q, pfd_d;

  logic        wr_hit;
  logic        rd_hit;
  logic [4:0]  addr;
  logic [15:0] wd;

  always_comb begin
    addr   = mgmt_cmd.management_register_address;
    wd     = mgmt_cmd.wdata;
    wr_hit = mgmt_valid & mgmt_cmd.wr & sgmii_mode & spm_mapped(addr);
    rd_hit = mgmt_valid & ~mgmt_cmd.wr & sgmii_mode & spm_mapped(addr);
    lvl_d      = lvl_q;
    rst_tgl_d  = rst_tgl_q;
    rsn_tgl_d  = rsn_tgl_q;
    int_en_d   = int_en_q;
    int_stat_d = int_stat_q;
    rf_d       = rf_q;
    link_lat_d = link_lat_q;
    pgrx_d     = pgrx_q;
    np_tx_d    = np_tx_q;
    partner_d  = partner_q;
    pa_ack_d   = pa_ack_q;
    ack_d      = mgmt_valid;
    rdata_d    = 16'h0000;

    if (wr_hit && addr == ADDR_CTRL) begin
      if (wd[CTL_RESET]) begin
        lvl_d     = LVL_RST;
        rst_tgl_d = ~rst_tgl_q;
      end else begin
        lvl_d.lb_en  = wd[CTL_LOOP];
        lvl_d.an_en  = wd[CTL_AN_EN];
        lvl_d.pdown  = lvl_q.pdown | wd[CTL_PDOWN];
        lvl_d.iso    = wd[CTL_ISO];
        lvl_d.unidir = wd[CTL_UNIDIR];
        if (wd[CTL_AN_RST]) begin
          rsn_tgl_d = ~rsn_tgl_q;
        end
      end
    end
    if (wr_hit && addr == ADDR_LB_CTL) begin
      lvl_d.lb_pos = wd[LB_POS];
    end
    if (wr_hit && addr == ADDR_NP_TX) begin
      np_tx_d = (np_tx_q & ~NP_TX_WMASK) | (wd & NP_TX_WMASK);
    end
    if (wr_hit && addr == ADDR_INT_CTL) begin
      int_en_d   = wd[INT_EN];
      int_stat_d = int_stat_q & wd[INT_STAT];
    end
    // Event after the clear so a coincident completion is not lost
    if (an_evt && int_en_q) begin
      int_stat_d = 1'b1;
    end
    if (!int_en_q) begin
      int_stat_d = 1'b0;
    end

    if (rd_hit && addr == ADDR_STAT) begin
      rf_d       = 1'b0;
      link_lat_d = link_up_s;
    end
    if (rf_evt) begin
      rf_d = 1'b1;
    end
    if (!link_up_s) begin
      link_lat_d = 1'b0;
    end
    if (rd_hit && addr == ADDR_ANX) begin
      pgrx_d = 1'b0;
    end
    if (pg_evt) begin
      pgrx_d = 1'b1;
    end

    // Partner word held stable by the link side until acknowledged
    if (pa_req_sync_q[1] != pa_ack_q) begin
      partner_d = pa_hold_q;
      pa_ack_d  = pa_req_sync_q[1];
    end
    pspd_d = partner_q[LPA_SPD_LO +: 2];
    pfd_d  = partner_q[LPA_DUPLEX];

    if (rd_hit) begin
      case (addr)
        ADDR_CTRL: begin
          rdata_d              = CTRL_FIXED;
          rdata_d[CTL_LOOP]    = lvl_q.lb_en;
          rdata_d[CTL_AN_EN]   = lvl_q.an_en;
          rdata_d[CTL_PDOWN]   = lvl_q.pdown;
          rdata_d[CTL_ISO]     = lvl_q.iso;
          rdata_d[CTL_UNIDIR]  = lvl_q.unidir;
        end
        ADDR_STAT: begin
          rdata_d              = STAT_FIXED;
          rdata_d[STS_AN_DONE] = an_done_s;
          rdata_d[STS_RFAULT]  = rf_q;
          rdata_d[STS_LINK]    = link_lat_q;
        end
        ADDR_ID_HI:   rdata_d = ID_HIGH;
        ADDR_ID_LO:   rdata_d = ID_LOW;
        ADDR_ADV:     rdata_d = ADV_VAL;
        ADDR_LPA:     rdata_d = (partner_q & LPA_MASK) | LPA_FIXED;
        ADDR_ANX: begin
          rdata_d            = ANX_FIXED;
          rdata_d[ANX_PG_RX] = pgrx_q;
        end
        ADDR_NP_TX:   rdata_d = np_tx_q;
        ADDR_EXT:     rdata_d = EXT_VAL;
        ADDR_INT_CTL: rdata_d = {14'h0000, int_stat_q & int_en_q, int_en_q};
        ADDR_LB_CTL:  rdata_d = {15'h0000, lvl_q.lb_pos};
        default:      rdata_d = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      lvl_q      <= LVL_RST;
      rst_tgl_q  <= 1'b0;
      rsn_tgl_q  <= 1'b0;
      int_en_q   <= INT_EN_RST;
      int_stat_q <= 1'b0;
      rf_q       <= 1'b0;
      link_lat_q <= 1'b0;
      pgrx_q     <= 1'b0;
      np_tx_q    <= NP_TX_RST;
      partner_q  <= LPA_RST;
      pa_ack_q   <= 1'b0;
      ack_q      <= 1'b0;
      rdata_q    <= 16'h0000;
      pspd_q     <= 2'h0;
      pfd_q      <= 1'b0;
    end else begin
      lvl_q      <= lvl_d;
      rst_tgl_q  <= rst_tgl_d;
      rsn_tgl_q  <= rsn_tgl_d;
      int_en_q   <= int_en_d;
      int_stat_q <= int_stat_d;
      rf_q       <= rf_d;
      link_lat_q <= link_lat_d;
      pgrx_q     <= pgrx_d;
      np_tx_q    <= np_tx_d;
      partner_q  <= partner_d;
      pa_ack_q   <= pa_ack_d;
      ack_q      <= ack_d;
      rdata_q    <= rdata_d;
      pspd_q     <= pspd_d;
      pfd_q      <= pfd_d;
    end
  end

  assign mgmt_ack            = ack_q;
  assign mgmt_rdata          = rdata_q;
  assign partner_speed       = pspd_q;
  assign partner_full_duplex = pfd_q;

  // Link domain, clocked by the recovered transceiver clock
  logic [1:0]    lrst_q;
  spm_lvl_s      lvl_m_q, lvl_s_q;
  logic [2:0]    rtg_q;
  logic [2:0]    ntg_q;
  logic [1:0]    pa_ack_sync_q;
  logic          an_lvl_d;
  logic          lk_lvl_d;
  logic          rf_tgl_d;
  logic          pg_tgl_d;
  logic          pa_req_d;
  logic [15:0]   pa_hold_d;
  spm_lnk_ctrl_s ctrl_q, ctrl_d;
  logic          lrst_n;
  assign lrst_n = lrst_q[1];

  // Reset enters the link domain at once and leaves it synchronised,
  // so a short system reset still clears the link side in time
  always_ff @(posedge clk_link or negedge rst_n) begin
    if (!rst_n) begin
      lrst_q <= 2'h0;
    end else begin
      lrst_q <= {lrst_q[0], 1'b1};
    end
  end

  always_comb begin
    an_lvl_d  = lnk_stat.an_complete;
    lk_lvl_d  = lnk_stat.link_up;
    rf_tgl_d  = rf_tgl_q ^ lnk_stat.remote_fault;
    pg_tgl_d  = pg_tgl_q ^ lnk_stat.page_rx;
    pa_req_d  = pa_req_q;
    pa_hold_d = pa_hold_q;
    // New word only once the previous one was taken
    if (pa_ack_sync_q[1] == pa_req_q && lnk_partner != pa_hold_q) begin
      pa_hold_d = lnk_partner;
      pa_req_d  = ~pa_req_q;
    end
    ctrl_d.pcs_reset     = rtg_q[1] ^ rtg_q[2];
    ctrl_d.an_restart    = ntg_q[1] ^ ntg_q[2];
    ctrl_d.pcs_loopback  = lvl_s_q.lb_en & ~lvl_s_q.lb_pos;
    ctrl_d.tx_idle_force = lvl_s_q.lb_en & ~lvl_s_q.lb_pos;
    ctrl_d.xcvr_loopback = lvl_s_q.lb_en & lvl_s_q.lb_pos;
    ctrl_d.power_down    = lvl_s_q.pdown;
    ctrl_d.isolate       = lvl_s_q.iso;
    ctrl_d.an_enable     = lvl_s_q.an_en;
    ctrl_d.unidir        = lvl_s_q.unidir;
  end

  // Control levels are quasi-static; a bit may lag its neighbours by one link cycle
  always_ff @(posedge clk_link) begin
    if (!lrst_n) begin
      lvl_m_q       <= LVL_RST;
      lvl_s_q       <= LVL_RST;
      rtg_q         <= 3'h0;
      ntg_q         <= 3'h0;
      pa_ack_sync_q <= 2'h0;
      an_lvl_q      <= 1'b0;
      lk_lvl_q      <= 1'b0;
      rf_tgl_q      <= 1'b0;
      pg_tgl_q      <= 1'b0;
      pa_req_q      <= 1'b0;
      pa_hold_q     <= LPA_RST;
      ctrl_q        <= '0;
    end else begin
      lvl_m_q       <= lvl_q;
      lvl_s_q       <= lvl_m_q;
      rtg_q         <= {rtg_q[1:0], rst_tgl_q};
      ntg_q         <= {ntg_q[1:0], rsn_tgl_q};
      pa_ack_sync_q <= {pa_ack_sync_q[0], pa_ack_q};
      an_lvl_q      <= an_lvl_d;
      lk_lvl_q      <= lk_lvl_d;
      rf_tgl_q      <= rf_tgl_d;
      pg_tgl_q      <= pg_tgl_d;
      pa_req_q      <= pa_req_d;
      pa_hold_q     <= pa_hold_d;
      ctrl_q        <= ctrl_d;
    end
  end

  assign lnk_ctrl = ctrl_q;

  logic ctl_rd;
  logic ctl_wr;
  assign ctl_rd = mgmt_valid & ~mgmt_cmd.wr & sgmii_mode & (addr == ADDR_CTRL);
  assign ctl_wr = mgmt_valid & mgmt_cmd.wr & sgmii_mode & (addr == ADDR_CTRL);

  chk_ack_timing: assert property (@(posedge clk_sys) disable iff (!rst_n)
    mgmt_valid |=> mgmt_ack ##1 !mgmt_ack || $past(mgmt_valid))
    else $error("ack not one cycle after request");
  chk_speed_const: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ctl_rd |=> !mgmt_rdata[CTL_SPD_LSB] && mgmt_rdata[CTL_SPD_MSB])
    else $error("speed bits wrong");
  chk_ctrl_fixed: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ctl_rd |=> mgmt_rdata[CTL_DUPLEX] && !mgmt_rdata[CTL_COLTEST] && mgmt_rdata[4:0] == 5'h00)
    else $error("control fixed bits wrong");
  chk_status_fixed: assert property (@(posedge clk_sys) disable iff (!rst_n)
    rd_hit && addr == ADDR_STAT |=> mgmt_rdata[15:9] == 7'h00 &&
      mgmt_rdata[8:6] == 3'h7 && mgmt_rdata[3])
    else $error("status fixed bits wrong");
  chk_an_done_read: assert property (@(posedge clk_sys) disable iff (!rst_n)
    rd_hit && addr == ADDR_STAT |=> mgmt_rdata[STS_AN_DONE] == $past(an_done_s))
    else $error("completion bit mismatch");
  chk_fault_sticky: assert property (@(posedge clk_sys) disable iff (!rst_n)
    rf_evt |=> rf_q)
    else $error("remote fault lost");
  chk_irq_gate: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (an_evt && int_en_q) or !int_en_q |=> int_stat_q == $past(int_en_q))
    else $error("interrupt status wrong");
  chk_pcs_reset: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ctl_wr && mgmt_cmd.wdata[CTL_RESET] |=> !lvl_q.pdown && lvl_q.an_en &&
      rst_tgl_q != $past(rst_tgl_q))
    else $error("pcs reset did not restore defaults");
  chk_pdown_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
    lvl_q.pdown && !(ctl_wr && mgmt_cmd.wdata[CTL_RESET]) |=> lvl_q.pdown)
    else $error("power down cleared without reset");
  chk_unmapped_zero: assert property (@(posedge clk_sys) disable iff (!rst_n)
    mgmt_valid && !mgmt_cmd.wr && !spm_mapped(addr) |=> mgmt_rdata == 16'h0000)
    else $error("unmapped read not zero");
  chk_lb_pcs_idle: assert property (@(posedge clk_link) disable iff (!lrst_n)
    lvl_s_q.lb_en && !lvl_s_q.lb_pos |=> lnk_ctrl.tx_idle_force && !lnk_ctrl.xcvr_loopback)
    else $error("pcs loopback without idles");
  chk_lb_xcvr: assert property (@(posedge clk_link) disable iff (!lrst_n)
    lvl_s_q.lb_en && lvl_s_q.lb_pos |=> lnk_ctrl.xcvr_loopback && !lnk_ctrl.tx_idle_force)
    else $error("transceiver loopback wrong");
endmodule
`default_nettype wire

// File: sim/spm_phy_model.sv
`default_nettype none
module spm_phy_model (
  input  wire logic                  clk_link,
  input  wire logic                  an_done,
  input  wire logic                  link_ok,
  input  wire logic                  fault_tgl,
  input  wire logic                  page_tgl,
  input  wire logic [15:0]           word,
  input  wire spm_pkg::spm_lnk_ctrl_s lnk_ctrl,
  output var spm_pkg::spm_lnk_stat_s lnk_stat,
  output var logic [15:0]            lnk_partner,
  output var int                     rst_cnt,
  output var int                     rsr_cnt
);
  timeunit 1ns;
  timeprecision 100ps;
  import spm_pkg::*;
  logic ft_q = 1'b0;
  logic pt_q = 1'b0;
  initial begin
    lnk_stat = '0;
    lnk_partner = LPA_RST;
    rst_cnt = 0;
    rsr_cnt = 0;
  end
  // Bench raises an_done only after the partner word has settled
  always @(posedge clk_link) begin
    lnk_partner <= word;
    lnk_stat.an_complete <= an_done;
    lnk_stat.link_up <= link_ok;
    // Toggle requests become single-cycle events, never two in a row
    lnk_stat.remote_fault <= fault_tgl ^ ft_q;
    lnk_stat.page_rx <= page_tgl ^ pt_q;
    ft_q <= fault_tgl;
    pt_q <= page_tgl;
    if (lnk_ctrl.pcs_reset === 1'b1) begin
      rst_cnt <= rst_cnt + 1;
    end
    if (lnk_ctrl.an_restart === 1'b1) begin
      rsr_cnt <= rsr_cnt + 1;
    end
  end
endmodule
`default_nettype wire

// File: sim/spm_sgmii_pcs_mgmt_tb.sv
`default_nettype none
module spm_sgmii_pcs_mgmt_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import spm_pkg::*;
  logic          clk_sys = 1'b0;
  logic          clk_link = 1'b0;
  logic          rst_n = 1'b0;
  logic          sgmii_mode = 1'b1;
  logic          mgmt_valid = 1'b0;
  spm_mgmt_req_s mgmt_cmd = '0;
  logic          mgmt_ack;
  logic [15:0]   mgmt_rdata;
  logic [1:0]    partner_speed;
  logic          partner_full_duplex;
  spm_lnk_stat_s lnk_stat;
  logic [15:0]   lnk_partner;
  spm_lnk_ctrl_s lnk_ctrl;
  logic          an_done = 1'b0;
  logic          link_ok = 1'b0;
  logic          fault_tgl = 1'b0;
  logic          page_tgl = 1'b0;
  logic [15:0]   word = LPA_RST;
  int            rst_cnt;
  int            rsr_cnt;
  int            rst_e = 0;
  int            rsr_e = 0;
  int            bad_count = 0;
  int            cmp_count = 0;
  integer        seed = 71;
  logic [31:0]   exp_q[$];
  logic [15:0]   ctl_e = 16'h1140;
  logic [15:0]   np_e = NP_TX_RST;
  logic          int_en = INT_EN_RST;
  logic          int_st = 1'b0;
  logic          lb_e = 1'b0;

  always #5 clk_sys = ~clk_sys;
  // Link clock free of any phase tie to the system clock
  initial begin
    #3.3;
    forever #6 clk_link = ~clk_link;
  end

  // Identity values are arbitrary
  spm_sgmii_pcs_mgmt #(.ID_HIGH(16'h3c5a), .ID_LOW(16'ha5c3)) i_spm_sgmii_pcs_mgmt (
    .clk_sys(clk_sys), .rst_n(rst_n), .clk_link(clk_link), .sgmii_mode(sgmii_mode),
    .mgmt_valid(mgmt_valid), .mgmt_cmd(mgmt_cmd), .mgmt_ack(mgmt_ack),
    .mgmt_rdata(mgmt_rdata), .partner_speed(partner_speed),
    .partner_full_duplex(partner_full_duplex), .lnk_stat(lnk_stat),
    .lnk_partner(lnk_partner), .lnk_ctrl(lnk_ctrl));
  spm_phy_model i_spm_phy_model (
    .clk_link(clk_link), .an_done(an_done), .link_ok(link_ok), .fault_tgl(fault_tgl),
    .page_tgl(page_tgl), .word(word), .lnk_ctrl(lnk_ctrl), .lnk_stat(lnk_stat),
    .lnk_partner(lnk_partner), .rst_cnt(rst_cnt), .rsr_cnt(rsr_cnt));

  task automatic cmp_rd(input string what, input logic [31:0] e, input logic [15:0] got);
    cmp_count++;
    if ((got & e[31:16]) !== e[15:0]) begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, e[15:0], got);
    end
  endtask

  task automatic cmp_val(input string what, input logic [15:0] e, input logic [15:0] got);
    cmp_count++;
    if (got !== e) begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, e, got);
    end
  endtask

  // Read-clear bits are masked out here; exact reads go through rdx
  function automatic logic [31:0] exp_rd(input logic [4:0] a);
    logic [15:0] v;
    logic [15:0] m;
    m = 16'hffff;
    v = 16'h0000;
    if (sgmii_mode) begin
      case (a)
        ADDR_CTRL: v = ctl_e;
        ADDR_STAT: begin
          v = STAT_FIXED | {10'h0, an_done, 5'h0};
          m = 16'hffeb;
        end
        ADDR_ID_HI: v = 16'h3c5a;
        ADDR_ID_LO: v = 16'ha5c3;
        ADDR_ADV: v = ADV_VAL;
        ADDR_LPA: v = (word & LPA_MASK) | LPA_FIXED;
        ADDR_ANX: begin
          v = ANX_FIXED;
          m = 16'hfffd;
        end
        ADDR_NP_TX: v = np_e;
        ADDR_EXT: v = EXT_VAL;
        ADDR_INT_CTL: v = {14'h0, int_st, int_en};
        ADDR_LB_CTL: v = {15'h0, lb_e};
        default: v = 16'h0000;
      endcase
    end
    return {m, v & m};
  endfunction

  task automatic acc(input logic w, input logic [4:0] a, input logic [15:0] d,
                     input logic [31:0] e);
    @(posedge clk_sys);
    mgmt_valid <= 1'b1;
    mgmt_cmd <= {w, a, d};
    exp_q.push_back(w ? 32'hffff_0000 : e);
  endtask

  task automatic idle(input int n);
    @(posedge clk_sys);
    mgmt_valid <= 1'b0;
    repeat (n) @(posedge clk_sys);
  endtask

  task automatic rd(input logic [4:0] a);
    acc(1'b0, a, 16'h0000, exp_rd(a));
  endtask

  task automatic rdx(input logic [4:0] a, input logic [15:0] v);
    acc(1'b0, a, 16'h0000, {16'hffff, v});
  endtask

  task automatic wreg(input logic [4:0] a, input logic [15:0] d);
    acc(1'b1, a, d, 32'h0000_0000);
    if (sgmii_mode) begin
      case (a)
        ADDR_CTRL: begin
          ctl_e = d[15] ? 16'h1140 : ((d & 16'h5c20) | CTRL_FIXED | (ctl_e & 16'h0800));
          rst_e += d[15];
          rsr_e += d[9] & ~d[15];
        end
        ADDR_NP_TX: np_e = d & NP_TX_WMASK;
        ADDR_INT_CTL: begin
          int_en = d[INT_EN];
          int_st = int_st & d[INT_STAT] & d[INT_EN];
        end
        ADDR_LB_CTL: lb_e = d[LB_POS];
        default: ;
      endcase
    end
  endtask

  task automatic chk_lnk();
    logic [15:0] e;
    int n;
    e = {9'h0, ctl_e[14] & ~lb_e, ctl_e[14] & lb_e, ctl_e[14] & ~lb_e,
         ctl_e[11], ctl_e[10], ctl_e[12], ctl_e[5]};
    n = 0;
    idle(0);
    while (n < 40 && {9'h0, lnk_ctrl[6:0]} !== e) begin
      @(posedge clk_sys);
      n++;
    end
    cmp_val("lnk_ctrl", e, {9'h0, lnk_ctrl[6:0]});
  endtask

  task automatic end_test(input string name);
    idle(3);
    cmp_val("pending acks", 16'h0000, 16'(exp_q.size()));
    $display("Test %s done", name);
  endtask

  task automatic end_sim();
    $display("Comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  always @(posedge clk_sys) begin
    if (rst_n === 1'b1 && mgmt_ack === 1'b1) begin
      if (exp_q.size() == 0) begin
        bad_count++;
        $display("Error mgmt_ack expected 0 seen 1");
      end else begin
        cmp_rd("mgmt_rdata", exp_q.pop_front(), mgmt_rdata);
      end
    end
  end

  initial begin
    #200us;
    bad_count++;
    $display("Error watchdog expected finish seen timeout");
    end_sim();
  end

  initial begin
    logic [15:0] d;
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    for (int a = 0; a < 32; a++) rd(a[4:0]);
    rdx(ADDR_STAT, STAT_FIXED);
    end_test("reset and decode");

    for (int i = 0; i < 3; i++) begin
      d = 16'($random(seed));
      d[15] = 1'b0;
      d[9] = 1'b0;
      wreg(ADDR_CTRL, d);
      rd(ADDR_CTRL);
    end
    wreg(ADDR_CTRL, 16'h0800);
    wreg(ADDR_CTRL, 16'h0000);
    rd(ADDR_CTRL);
    chk_lnk();
    wreg(ADDR_CTRL, 16'h9e20);
    rd(ADDR_CTRL);
    idle(10);
    wreg(ADDR_CTRL, 16'h1200);
    rd(ADDR_CTRL);
    chk_lnk();
    idle(30);
    cmp_val("pcs_reset pulses", rst_e[15:0], rst_cnt[15:0]);
    cmp_val("an_restart pulses", rsr_e[15:0], rsr_cnt[15:0]);
    end_test("control");

    wreg(ADDR_CTRL, 16'h5000);
    chk_lnk();
    wreg(ADDR_LB_CTL, 16'hffff);
    rd(ADDR_LB_CTL);
    chk_lnk();
    wreg(ADDR_CTRL, 16'h1000);
    chk_lnk();
    end_test("loopback");

    for (int s = 0; s < 4; s++) begin
      d = 16'($random(seed));
      word <= {d[15:12], s[1:0], d[9:0]};
      idle(30);
      cmp_val("partner_speed", {14'h0, s[1:0]}, {14'h0, partner_speed});
      cmp_val("partner_full_duplex", {15'h0, d[12]}, {15'h0, partner_full_duplex});
      rd(ADDR_LPA);
    end
    an_done <= 1'b1;
    int_st = int_en;
    idle(30);
    rd(ADDR_STAT);
    rdx(ADDR_INT_CTL, 16'h0003);
    wreg(ADDR_INT_CTL, 16'h0001);
    rdx(ADDR_INT_CTL, 16'h0001);
    wreg(ADDR_INT_CTL, 16'h0000);
    an_done <= 1'b0;
    idle(30);
    an_done <= 1'b1;
    idle(30);
    rdx(ADDR_INT_CTL, 16'h0000);
    wreg(ADDR_INT_CTL, 16'h0001);
    end_test("negotiation");

    fault_tgl <= 1'b1;
    page_tgl <= 1'b1;
    idle(30);
    rdx(ADDR_STAT, STAT_FIXED | 16'h0030);
    rdx(ADDR_STAT, STAT_FIXED | 16'h0020);
    rdx(ADDR_ANX, ANX_FIXED | 16'h0002);
    rdx(ADDR_ANX, ANX_FIXED);
    link_ok <= 1'b1;
    idle(30);
    rd(ADDR_STAT);
    rdx(ADDR_STAT, STAT_FIXED | 16'h0024);
    link_ok <= 1'b0;
    idle(30);
    link_ok <= 1'b1;
    idle(30);
    rdx(ADDR_STAT, STAT_FIXED | 16'h0020);
    rdx(ADDR_STAT, STAT_FIXED | 16'h0024);
    end_test("status events");

    idle(1);
    sgmii_mode <= 1'b0;
    wreg(ADDR_CTRL, 16'h4000);
    rd(ADDR_CTRL);
    idle(1);
    sgmii_mode <= 1'b1;
    idle(0);
    rd(ADDR_CTRL);
    end_test("interface mode");

    for (int i = 0; i < 40; i++) begin
      d = 16'($random(seed));
      if (d[0]) begin
        d[15] = 1'b0;
        d[9] = 1'b0;
        d[1] = 1'b0;
        wreg(d[8:4], d);
      end else begin
        rd(d[8:4]);
      end
    end
    chk_lnk();
    end_test("random traffic");
    end_sim();
  end
endmodule
`default_nettype wire
